// ---- sfcf_consts.vh ----
// Constants for the serial flash command framing block
`ifndef SFCF_CONSTS_VH
`define SFCF_CONSTS_VH
`define SFCF_INSTR_BITS 8
`define SFCF_INSTR_CNT 6'h08
`define SFCF_ADDR_BITS 32
`define SFCF_CNT_W 6
`define SFCF_PAGE_BYTES 512
`define SFCF_PAGE_AW 9
`define SFCF_SECTOR_KBYTES 256
`define SFCF_SECTOR_AW 18
`define SFCF_MSB_BYTE 7
`define SFCF_ZERO_CNT 6'h00
`define SFCF_ONE_CNT 6'h01
`define SFCF_LAST_BIT 3'h7
`endif

// ---- sfcf_sync.v ----
// Two-stage synchroniser for one pin level
`timescale 1ns/1ps
module sfcf_sync #(
   parameter RST_VAL = 1'b1
) (
   input wire clk,
   input wire nrst,
   input wire din,
   output reg dout
);
   reg stage1;
   // Second stage alone reads the first; reset to the pin's idle level
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // sfcf_sync

// ---- sfcf_frame.v ----
// Command framing for a serial flash slave port, sampled SPI link
`timescale 1ns/1ps
`include "sfcf_consts.vh"
module sfcf_frame (
   input wire CORE_CLK,
   input wire NRST,
   input wire SCK,
   input wire CS_N,
   input wire SI,
   output reg SO,
   output reg SO_OE,
   input wire DDR_MODE,
   input wire [`SFCF_CNT_W-1:0] ADDR_BITS,
   input wire [`SFCF_CNT_W-1:0] MODE_BITS,
   input wire [`SFCF_CNT_W-1:0] LATENCY_CYCLES,
   input wire PHASE_LOAD,
   input wire [7:0] TX_BYTE,
   output wire TX_READY,
   output reg [7:0] INSTR,
   output reg INSTR_VALID,
   output reg [`SFCF_ADDR_BITS-1:0] ADDR,
   output reg ADDR_VALID,
   output reg [7:0] MODE,
   output reg [7:0] RX_BYTE,
   output reg RX_VALID,
   output reg CMD_END,
   output reg [`SFCF_ADDR_BITS-1:0] PAGE_BASE,
   output reg [`SFCF_ADDR_BITS-1:0] SECTOR_BASE
);
   ////////////////////////////////////////////////////////////////////
   localparam ST_IDLE = 6'h01;
   localparam ST_INSTR = 6'h02;
   localparam ST_ADDR = 6'h04;
   localparam ST_MODE = 6'h08;
   localparam ST_LAT = 6'h10;
   localparam ST_DATA = 6'h20;

   wire sck_s;
   wire cs_s;
   wire si_s;
   reg sck_d;
   reg [5:0] state;
   reg [5:0] next_state;
   reg [`SFCF_CNT_W-1:0] cnt;
   reg [`SFCF_ADDR_BITS-1:0] shift;
   reg [2:0] bitpos;
   reg [7:0] tx_sh;
   reg [2:0] tx_pos;
   reg tx_busy;

   // Pins into the core clock domain; idle levels avoid a false edge
   sfcf_sync #(.RST_VAL(1'b0)) u_sck (.clk(CORE_CLK), .nrst(NRST),
      .din(SCK), .dout(sck_s));
   sfcf_sync #(.RST_VAL(1'b1)) u_cs (.clk(CORE_CLK), .nrst(NRST),
      .din(CS_N), .dout(cs_s));
   sfcf_sync #(.RST_VAL(1'b1)) u_si (.clk(CORE_CLK), .nrst(NRST),
      .din(SI), .dout(si_s));

   ////////////////////////////////////////////////////////////////////
   // Edge detection on the sampled link clock
   wire rise = sck_s & ~sck_d;
   wire fall = ~sck_s & sck_d;
   wire active = ~cs_s;
   wire cap = active & (rise | (DDR_MODE & fall));
   wire shout = active & (DDR_MODE ? (rise | fall) : fall);
   wire cnt_done = (cnt == `SFCF_ONE_CNT);
   wire [`SFCF_ADDR_BITS-1:0] shifted = {shift[`SFCF_ADDR_BITS-2:0], si_s};

   assign TX_READY = active & (state == ST_DATA) & ~tx_busy;

   // Phase sequencing
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (active)
               next_state = ST_INSTR;
         end
         ST_INSTR: begin
            if (cap && cnt_done) begin
               if (ADDR_BITS != `SFCF_ZERO_CNT)
                  next_state = ST_ADDR;
               else if (MODE_BITS != `SFCF_ZERO_CNT)
                  next_state = ST_MODE;
               else if (LATENCY_CYCLES != `SFCF_ZERO_CNT)
                  next_state = ST_LAT;
               else
                  next_state = ST_DATA;
            end
         end
         ST_ADDR: begin
            if (cap && cnt_done) begin
               if (MODE_BITS != `SFCF_ZERO_CNT)
                  next_state = ST_MODE;
               else if (LATENCY_CYCLES != `SFCF_ZERO_CNT)
                  next_state = ST_LAT;
               else
                  next_state = ST_DATA;
            end
         end
         ST_MODE: begin
            if (cap && cnt_done) begin
               if (LATENCY_CYCLES != `SFCF_ZERO_CNT)
                  next_state = ST_LAT;
               else
                  next_state = ST_DATA;
            end
         end
         ST_LAT: begin
            if (rise && cnt_done)
               next_state = ST_DATA;
         end
         ST_DATA: next_state = ST_DATA;
         default: next_state = ST_IDLE;
      endcase
      if (!active)
         next_state = ST_IDLE;
   end

   ////////////////////////////////////////////////////////////////////
   // Receive path and phase counters
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         sck_d <= 1'b0;
         state <= ST_IDLE;
         cnt <= `SFCF_ZERO_CNT;
         shift <= {`SFCF_ADDR_BITS{1'b0}};
         bitpos <= 3'h0;
         INSTR <= 8'h00;
         INSTR_VALID <= 1'b0;
         ADDR <= {`SFCF_ADDR_BITS{1'b0}};
         ADDR_VALID <= 1'b0;
         MODE <= 8'h00;
         RX_BYTE <= 8'h00;
         RX_VALID <= 1'b0;
         CMD_END <= 1'b0;
         PAGE_BASE <= {`SFCF_ADDR_BITS{1'b0}};
         SECTOR_BASE <= {`SFCF_ADDR_BITS{1'b0}};
      end else begin
         sck_d <= sck_s;
         state <= next_state;
         INSTR_VALID <= 1'b0;
         ADDR_VALID <= 1'b0;
         RX_VALID <= 1'b0;
         CMD_END <= (state != ST_IDLE) && !active;
         if (cap)
            shift <= shifted;
         case (state)
            ST_IDLE: begin
               cnt <= `SFCF_INSTR_CNT;
               bitpos <= 3'h0;
            end
            ST_INSTR: begin
               if (cap) begin
                  cnt <= cnt - `SFCF_ONE_CNT;
                  if (cnt_done) begin
                     INSTR <= shifted[7:0];
                     INSTR_VALID <= 1'b1;
                     cnt <= (ADDR_BITS != `SFCF_ZERO_CNT) ? ADDR_BITS :
                        (MODE_BITS != `SFCF_ZERO_CNT) ? MODE_BITS :
                        LATENCY_CYCLES;
                  end
               end
            end
            ST_ADDR: begin
               if (cap) begin
                  cnt <= cnt - `SFCF_ONE_CNT;
                  if (cnt_done) begin
                     ADDR <= shifted;
                     ADDR_VALID <= 1'b1;
                     // Page and sector bases for program and erase
                     PAGE_BASE <= {shifted[`SFCF_ADDR_BITS-1:
                        `SFCF_PAGE_AW], {`SFCF_PAGE_AW{1'b0}}};
                     SECTOR_BASE <= {shifted[`SFCF_ADDR_BITS-1:
                        `SFCF_SECTOR_AW], {`SFCF_SECTOR_AW{1'b0}}};
                     cnt <= (MODE_BITS != `SFCF_ZERO_CNT) ? MODE_BITS :
                        LATENCY_CYCLES;
                  end
               end
            end
            ST_MODE: begin
               if (cap) begin
                  cnt <= cnt - `SFCF_ONE_CNT;
                  if (cnt_done) begin
                     MODE <= shifted[7:0];
                     cnt <= LATENCY_CYCLES;
                  end
               end
            end
            ST_LAT: begin
               if (rise)
                  cnt <= cnt - `SFCF_ONE_CNT; // Latency counts clocks
            end
            ST_DATA: begin
               if (cap) begin
                  bitpos <= bitpos + 3'h1;
                  if (bitpos == `SFCF_LAST_BIT) begin
                     RX_BYTE <= shifted[7:0];
                     RX_VALID <= 1'b1;
                  end
               end
            end
            default: cnt <= `SFCF_ZERO_CNT;
         endcase
         if (!active)
            bitpos <= 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transmit path, most significant bit first
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         tx_sh <= 8'h00;
         tx_pos <= 3'h0;
         tx_busy <= 1'b0;
         SO <= 1'b0;
         SO_OE <= 1'b0;
      end else if (!active) begin
         tx_pos <= 3'h0;
         tx_busy <= 1'b0;
         SO_OE <= 1'b0;
      end else if (state == ST_DATA) begin
         if (PHASE_LOAD && !tx_busy) begin
            // Byte waits in the shifter until the next out edge
            tx_sh <= TX_BYTE;
            tx_pos <= `SFCF_LAST_BIT;
            tx_busy <= 1'b1;
            SO_OE <= 1'b1;
         end else if (shout && tx_busy) begin
            // Every bit, the first too, leaves on an out edge
            SO <= tx_sh[`SFCF_MSB_BYTE];
            tx_sh <= {tx_sh[6:0], 1'b0};
            tx_pos <= tx_pos - 3'h1;
            if (tx_pos == 3'h0)
               tx_busy <= 1'b0;
         end
      end
   end
   // write sequencing is left to the array controller behind INSTR
endmodule // sfcf_frame

// ---- sfcf_checker.sv ----
// Port checker for the command framing block
`timescale 1ns/1ps
`include "sfcf_consts.vh"
module sfcf_checker (
   input wire CORE_CLK,
   input wire NRST,
   input wire CS_N,
   input wire SO_OE,
   input wire INSTR_VALID,
   input wire CMD_END,
   input wire ADDR_VALID,
   input wire [`SFCF_ADDR_BITS-1:0] ADDR,
   input wire [`SFCF_ADDR_BITS-1:0] PAGE_BASE,
   input wire [`SFCF_ADDR_BITS-1:0] SECTOR_BASE
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   a_page_align: assert property (PAGE_BASE[8:0] == 9'h000)
      else $error("page base misaligned");
   a_sector_align: assert property (SECTOR_BASE[17:0] == 18'h00000)
      else $error("sector base misaligned");
   a_end_deselect: assert property
      (CMD_END |-> CS_N && $past(CS_N, 2))
      else $error("end while selected");
   a_end_pulse: assert property (CMD_END |=> !CMD_END)
      else $error("end pulse too long");
   a_oe_idle: assert property (CS_N [*5] |-> !SO_OE)
      else $error("driving while deselected");
   a_instr_sel: assert property (INSTR_VALID |-> !$past(CS_N, 3))
      else $error("instruction outside command");
   a_instr_pulse: assert property (INSTR_VALID |=> !INSTR_VALID)
      else $error("instruction pulse too long");
   a_reset_idle: assert property (disable iff (1'b0)
      !NRST |-> !SO_OE && !CMD_END)
      else $error("active in reset");
   a_page_follow: assert property
      (ADDR_VALID |-> PAGE_BASE[`SFCF_ADDR_BITS-1:`SFCF_PAGE_AW] ==
      ADDR[`SFCF_ADDR_BITS-1:`SFCF_PAGE_AW])
      else $error("page base not from address");
   a_sector_follow: assert property
      (ADDR_VALID |-> SECTOR_BASE[`SFCF_ADDR_BITS-1:`SFCF_SECTOR_AW] ==
      ADDR[`SFCF_ADDR_BITS-1:`SFCF_SECTOR_AW])
      else $error("sector base not from address");
   // Main scenarios reached
   cover property (INSTR_VALID);
   cover property (ADDR_VALID);
   cover property (CMD_END);
   cover property (SO_OE);
endmodule // sfcf_checker
bind sfcf_frame sfcf_checker sfcf_checker_inst (.CORE_CLK(CORE_CLK),
   .NRST(NRST), .CS_N(CS_N), .SO_OE(SO_OE), .INSTR_VALID(INSTR_VALID),
   .CMD_END(CMD_END), .ADDR_VALID(ADDR_VALID), .ADDR(ADDR),
   .PAGE_BASE(PAGE_BASE), .SECTOR_BASE(SECTOR_BASE));

// ---- sfcf_host.sv ----
// Host controller model driving the serial link
`timescale 1ns/1ps
module sfcf_host (
   output reg sck,
   output reg cs_n,
   output reg si,
   input wire so
);
   // Link clock stands low outside frames
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b1;
   end
   // Select opens one command
   task open_cmd;
      begin
         #150 cs_n = 1'b0;
      end
   endtask
   // MSB first; rising edge only, or every edge in double rate
   task xfer(input [7:0] b, input integer n, input ddr, output [7:0] r);
      integer i;
      begin
         r = 8'h00;
         for (i = n - 1; i >= 0; i = i - 1) begin
            si = b[i];
            if (ddr) begin
               #100 sck = ~sck;
               r = {r[6:0], so};
               #100;
            end else begin
               #200 sck = 1'b1;
               r = {r[6:0], so};
               #200 sck = 1'b0;
            end
         end
      end
   endtask
   // Deselect ends the command; released line shows the inverse
   task close_cmd;
      begin
         #100 cs_n = 1'b1;
         si = ~si;
         #400;
      end
   endtask
endmodule // sfcf_host

// ---- sfcf_frame_tb_top.sv ----
// Self-checking bench for the command framing block
`timescale 1ns/1ps
module sfcf_frame_tb_top;
   reg clk, nrst, ddr, load;
   reg [5:0] ab, mb, lat;
   reg [7:0] txb, r;
   wire sck, cs_n, si, so, rdy, iv, ce;
   wire oe, av, rv, so_line;
   wire [7:0] instr, mode, rxb;
   wire [31:0] addr, pb, sb;
   integer mismatches = 0;
   integer n_tests = 0;
   integer cyc = 0;
   integer n_iv, n_ce, n_av, n_rv, i;
   // Released data line shows the inverse of its last level
   assign so_line = oe ? so : ~so;
   sfcf_host sfcf_host_inst (.sck(sck), .cs_n(cs_n), .si(si),
      .so(so_line));
   sfcf_frame sfcf_frame_inst (.CORE_CLK(clk), .NRST(nrst), .SCK(sck),
      .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(oe), .DDR_MODE(ddr),
      .ADDR_BITS(ab), .MODE_BITS(mb), .LATENCY_CYCLES(lat),
      .PHASE_LOAD(load), .TX_BYTE(txb), .TX_READY(rdy), .INSTR(instr),
      .INSTR_VALID(iv), .ADDR(addr), .ADDR_VALID(av), .MODE(mode),
      .RX_BYTE(rxb), .RX_VALID(rv), .CMD_END(ce), .PAGE_BASE(pb),
      .SECTOR_BASE(sb));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Pulse counters and run limit
   always @(posedge clk) begin
      n_iv <= n_iv + iv;
      n_ce <= n_ce + ce;
      n_av <= n_av + av;
      n_rv <= n_rv + rv;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches = mismatches + 1;
         end_of_test;
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task x(input [7:0] b, input integer n, input d);
      begin
         sfcf_host_inst.xfer(b, n, d, r);
      end
   endtask
   // Phase lengths and rate set off the sampling edge
   task cfg(input [5:0] a, input [5:0] m, input [5:0] l, input d);
      begin
         @(negedge clk);
         ab = a;
         mb = m;
         lat = l;
         ddr = d;
         n_iv = 0;
         n_ce = 0;
         n_av = 0;
         n_rv = 0;
      end
   endtask
   // Reply byte loaded once the data phase opens
   task load_tx(input [7:0] b);
      begin
         for (i = 0; i < 400 && rdy !== 1'b1; i = i + 1) @(negedge clk);
         txb = b;
         load = 1'b1;
         @(negedge clk);
         load = 1'b0;
      end
   endtask
   task t_plain;
      begin
         cfg(6'h00, 6'h00, 6'h00, 1'b0);
         sfcf_host_inst.open_cmd;
         x(8'ha5, 8, 1'b0);
         x(8'h3c, 8, 1'b0);
         sfcf_host_inst.close_cmd;
         chk("instr", 32'ha5, instr);
         chk("rx", 32'h3c, rxb);
         chk("pulses", 32'h101, {n_iv[7:0], n_ce[7:0]});
         chk("valids", 32'h0001, {n_av[7:0], n_rv[7:0]});
         $display("t_plain end");
      end
   endtask
   task t_phases;
      begin
         cfg(6'h20, 6'h08, 6'h02, 1'b0);
         sfcf_host_inst.open_cmd;
         x(8'h0b, 8, 1'b0);
         for (i = 0; i < 4; i = i + 1)
            x(8'(32'h12345a67 >> (24 - 8 * i)), 8, 1'b0);
         x(8'hc3, 8, 1'b0);
         fork
            load_tx(8'h96);
            begin
               x(8'h00, 2, 1'b0);
               x(8'hff, 8, 1'b0);
            end
         join
         sfcf_host_inst.close_cmd;
         chk("read", 32'h96, r);
         chk("addr", 32'h12345a67, addr);
         chk("mode", 32'hc3, mode);
         chk("page", 32'h12345a00, pb);
         chk("sector", 32'h12340000, sb);
         chk("rx read", 32'hff, rxb);
         chk("valids", 32'h0101, {n_av[7:0], n_rv[7:0]});
         chk("oe off", 32'h0, oe);
         $display("t_phases end");
      end
   endtask
   // Reset and a cut byte in mid-command, then a double-rate command
   task t_cut;
      begin
         cfg(6'h00, 6'h00, 6'h00, 1'b0);
         sfcf_host_inst.open_cmd;
         x(8'hf0, 4, 1'b0);
         @(negedge clk);
         nrst = 1'b0;
         repeat (2) @(negedge clk);
         nrst = 1'b1;
         sfcf_host_inst.close_cmd;
         chk("reset instr", 32'h00, instr);
         sfcf_host_inst.open_cmd;
         x(8'h0f, 4, 1'b0);
         sfcf_host_inst.close_cmd;
         chk("cut pulses", 32'h0, n_iv);
         cfg(6'h00, 6'h00, 6'h00, 1'b1);
         sfcf_host_inst.open_cmd;
         x(8'hc6, 8, 1'b1);
         sfcf_host_inst.close_cmd;
         chk("ddr instr", 32'hc6, instr);
         $display("t_cut end");
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", n_tests, mismatches);
         if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      nrst = 1'b0;
      {ddr, load, ab, mb, lat, txb} = 28'h0000000;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_plain;
      t_phases;
      t_cut;
      end_of_test;
   end
endmodule // sfcf_frame_tb_top
